// >>> can_rx_filter_tx_handler.v
// CAN receive acceptance filtering and transmit message handler
// Summary of operation
// - Std priority filter match sets high-priority flag
// - Ext priority filter match sets high-priority flag
// - Global non-match acceptance never sets priority flag
// - Accept-encoded global setting accepts unmatched ext frames
// - Accept-encoded global setting accepts unmatched std frames
// - Ext store encodings route to FIFO 0/1
// - Std store encodings route to FIFO 0/1
// - Ext classic: value and mask, zero bits ignored
// - Std classic: value and mask, zero bits ignored
// - Queue mode clear: dedicated buffers plus FIFO
// - Rescan keeps three-slot pipeline in priority order
// - Failed attempt stays pending and retries later
// - FIFO messages leave in FIFO order while queue mode is clear; in queue mode they go by identifier
// - Equal identifiers go by ascending buffer number
// - Add-request starts buffer; completion sets flags
// - Last FIFO completion sets FIFO-empty flag
// - Arbitrate and load output buffer before request
//
// Implementation choices: the register offsets and the APB register port.
`default_nettype none
`include "can_filt_tx_regs.vh"

module can_rx_filter_tx_handler (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        rx_frame_valid,
  input  wire        rx_frame_ext,
  input  wire [28:0] rx_frame_id,
  output wire        rx_store_valid,
  output wire        rx_store_fifo1,
  output wire        tx_req,
  output wire [28:0] tx_id,
  output wire [2:0]  tx_index,
  input  wire        tx_done,
  input  wire        tx_fail,
  output wire        irq
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  reg [31:0] prdata_q;
  reg        pready_q;
  reg        pslverr_q;
  reg [31:0] global_filter_config_q;
  reg        tx_queue_mode_q;
  reg [2:0]  irq_status_q;
  reg [2:0]  irq_mask_q;
  reg        irq_q;
  reg [31:0] sflt_q [0:1];
  reg [31:0] ew0_q [0:1];
  reg [31:0] ew1_q [0:1];
  reg [28:0] tid_q [0:7];
  reg [3:0]  pend_q;
  reg [3:0]  tx_occurred_bits_q;
  reg [3:0]  fpend_q;
  reg [1:0]  put_q;
  reg [1:0]  get_q;
  reg        busy_q;
  reg [2:0]  p0_q;
  reg        v1_q;
  reg [2:0]  p1_q;
  reg        v2_q;
  reg [2:0]  p2_q;
  reg        tx_req_q;
  reg [28:0] tx_id_q;
  reg        rx_store_valid_q;
  reg        rx_store_fifo1_q;
  integer    i, j, k;
  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign rx_store_valid = rx_store_valid_q;
  assign rx_store_fifo1 = rx_store_fifo1_q;
  assign tx_req         = tx_req_q;
  assign tx_id          = tx_id_q;
  assign tx_index       = p0_q;
  assign irq            = irq_q;

  // --------------------------------------------------------------------
  // APB handshake and decode
  // --------------------------------------------------------------------
  wire wr = psel & penable & pready_q & pwrite;
  reg  [31:0] rdat;
  reg         mapped;
  always @* begin
    rdat   = 32'h00000000;
    mapped = 1'b1;
    if (paddr == `OFS_GLOBAL_FILTER_CONFIG) begin
      rdat = global_filter_config_q;
    end else if (paddr == `OFS_TX_CONFIG) begin
      rdat = {31'h00000000, tx_queue_mode_q};
    end else if (paddr == `OFS_IRQ_STATUS) begin
      rdat = {29'h00000000, irq_status_q};
    end else if (paddr == `OFS_IRQ_MASK) begin
      rdat = {29'h00000000, irq_mask_q};
    end else if (paddr == `OFS_TX_ADD_REQUEST) begin
      rdat = {28'h0000000, pend_q};
    end else if (paddr == `OFS_TX_OCCURRED_BITS) begin
      rdat = {28'h0000000, tx_occurred_bits_q};
    end else if (paddr == `OFS_TX_FIFO_PUSH) begin
      rdat = {24'h000000, fpend_q, get_q, put_q};
    end else if (paddr == `OFS_TX_PIPE_STATUS) begin
      rdat = {20'h00000, v2_q, p2_q, v1_q, p1_q, busy_q, p0_q};
    end else if (paddr == `OFS_STD_FILTER0) begin
      rdat = sflt_q[0];
    end else if (paddr == `OFS_STD_FILTER1) begin
      rdat = sflt_q[1];
    end else if (paddr == `OFS_EXT_FILTER0_W0) begin
      rdat = ew0_q[0];
    end else if (paddr == `OFS_EXT_FILTER0_W1) begin
      rdat = ew1_q[0];
    end else if (paddr == `OFS_EXT_FILTER1_W0) begin
      rdat = ew0_q[1];
    end else if (paddr == `OFS_EXT_FILTER1_W1) begin
      rdat = ew1_q[1];
    end else if ({paddr[7:4], 4'h0} == `OFS_TX_BUF_ID_BASE) begin
      rdat = {3'h0, tid_q[{1'b0, paddr[3:2]}]};
    end else begin
      mapped = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= psel & penable & ~pready_q;
      prdata_q  <= (psel & penable & ~pready_q & ~pwrite) ? rdat : 32'h0;
      pslverr_q <= psel & penable & ~pready_q & ~mapped;
    end
  end

  wire wr_ok = wr & ~pslverr_q;
  // --------------------------------------------------------------------
  // Receive acceptance filtering
  // --------------------------------------------------------------------
  wire [1:0] shit;
  wire [1:0] ehit;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : flt
      filter_match #(.W(11)) u_std (
        .id    (rx_frame_id[10:0]),
        .id_a  (sflt_q[g][`SF_IDA_LSB+10:`SF_IDA_LSB]),
        .id_b  (sflt_q[g][`SF_IDB_LSB+10:`SF_IDB_LSB]),
        .ftype (sflt_q[g][`SF_TYPE_LSB+1:`SF_TYPE_LSB]),
        .hit   (shit[g])
      );
      filter_match #(.W(29)) u_ext (
        .id    (rx_frame_id),
        .id_a  (ew0_q[g][28:0]),
        .id_b  (ew1_q[g][28:0]),
        .ftype (ew1_q[g][`EF_TYPE_LSB+1:`EF_TYPE_LSB]),
        .hit   (ehit[g])
      );
    end
  endgenerate

  reg       rx_acc;
  reg       rx_f1;
  reg       rx_prio;
  reg       rx_found;
  reg [2:0] cfg;
  reg       hit;
  reg [1:0] gsel;
  always @* begin
    {rx_acc, rx_f1, rx_prio, rx_found} = 4'h0;
    cfg      = `FC_OFF;
    hit      = 1'b0;
    for (i = 0; i < 2; i = i + 1) begin
      if (rx_frame_ext) begin
        cfg = ew0_q[i][`EF_CFG_LSB+2:`EF_CFG_LSB];
        hit = ehit[i];
      end else begin
        cfg = sflt_q[i][`SF_CFG_LSB+2:`SF_CFG_LSB];
        hit = shit[i];
      end
      if (!rx_found && cfg != `FC_OFF && hit) begin
        rx_found = 1'b1;
        rx_acc   = (cfg != `FC_REJECT) && (cfg != `FC_PRIO);
        rx_f1    = (cfg == `FC_FIFO1) || (cfg == `FC_PRIO_FIFO1);
        rx_prio  = cfg[2] && (cfg != `FC_STORE_ALT);
      end
    end
    gsel = rx_frame_ext ? global_filter_config_q[`NM_EXT_LSB+1:`NM_EXT_LSB]
                        : global_filter_config_q[`NM_STD_LSB+1:`NM_STD_LSB];
    if (!rx_found) begin
      rx_acc = (gsel == `GA_FIFO0) || (gsel == `GA_FIFO1);
      rx_f1  = (gsel == `GA_FIFO1);
      rx_prio = 1'b0;
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_store_valid_q <= 1'b0;
      rx_store_fifo1_q <= 1'b0;
    end else begin
      rx_store_valid_q <= rx_frame_valid & rx_acc;
      rx_store_fifo1_q <= rx_frame_valid & rx_acc & rx_f1;
    end
  end
  // --------------------------------------------------------------------
  // Transmit scan: two best candidates outside the active slot
  // --------------------------------------------------------------------
  reg [7:0]  elig;
  reg        v1;
  reg [2:0]  b1;
  reg [28:0] bid1;
  reg        v2;
  reg [2:0]  b2;
  reg [28:0] bid2;
  always @* begin
    elig = 8'h00;
    for (j = 0; j < 4; j = j + 1) begin
      elig[j]   = pend_q[j];
      elig[j+4] = fpend_q[j] &
                  (tx_queue_mode_q | (get_q == j[1:0]));
    end
    if (busy_q) begin
      elig[p0_q] = 1'b0;
    end
    {v1, b1, bid1} = 33'h0;
    {v2, b2, bid2} = 33'h0;
    for (j = 0; j < 8; j = j + 1) begin
      if (elig[j] && (!v1 || tid_q[j] < bid1)) begin
        v1   = 1'b1;
        b1   = j[2:0];
        bid1 = tid_q[j];
      end
    end
    for (j = 0; j < 8; j = j + 1) begin
      if (elig[j] && b1 != j[2:0] && (!v2 || tid_q[j] < bid2)) begin
        v2   = 1'b1;
        b2   = j[2:0];
        bid2 = tid_q[j];
      end
    end
  end

  // --------------------------------------------------------------------
  // Transmit pipeline, pending bits and FIFO pointers
  // --------------------------------------------------------------------
  wire       done_ev   = tx_done & busy_q;
  wire       fail_ev   = tx_fail & busy_q;
  wire       done_fifo = done_ev & p0_q[2];
  wire [3:0] done_ded  = done_ev & ~p0_q[2] ? (4'h1 << p0_q[1:0]) : 4'h0;
  wire [3:0] done_fbit = done_fifo ? (4'h1 << p0_q[1:0]) : 4'h0;
  wire       push      = wr_ok && paddr == `OFS_TX_FIFO_PUSH && !fpend_q[put_q];
  wire [3:0] push_bit  = push ? (4'h1 << put_q) : 4'h0;
  wire [3:0] add_bits  = (wr_ok && paddr == `OFS_TX_ADD_REQUEST) ?
                         pwdata[3:0] : 4'h0;
  wire [3:0] fpend_d   = (fpend_q & ~done_fbit) | push_bit;
  wire       tfe_ev    = done_fifo & (fpend_d == 4'h0);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q             <= 4'h0;
      tx_occurred_bits_q <= 4'h0;
      fpend_q            <= 4'h0;
      {put_q, get_q}     <= 4'h0;
      {busy_q, p0_q}     <= 4'h0;
      {v1_q, p1_q, v2_q, p2_q} <= 8'h00;
      {tx_req_q, tx_id_q} <= 30'h0;
    end else begin
      pend_q  <= (pend_q & ~done_ded) | add_bits;
      tx_occurred_bits_q <= (tx_occurred_bits_q & ~add_bits) | done_ded;
      fpend_q <= fpend_d;
      if (push) begin
        put_q <= put_q + 2'h1;
      end
      if (done_fifo && !tx_queue_mode_q) begin
        get_q <= get_q + 2'h1;
      end
      v1_q <= v1;
      p1_q <= b1;
      v2_q <= v2;
      p2_q <= b2;
      if (done_ev || fail_ev) begin
        busy_q   <= 1'b0;
        tx_req_q <= 1'b0;
      end else if (!busy_q && v1_q && elig[p1_q]) begin
        busy_q   <= 1'b1;
        p0_q     <= p1_q;
        tx_id_q  <= tid_q[p1_q];
        tx_req_q <= 1'b1;
      end
    end
  end
  // --------------------------------------------------------------------
  // Configuration and message identifier storage
  // --------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_filter_config_q <= `RST_GLOBAL_FILTER_CONFIG;
      tx_queue_mode_q <= `RST_TX_CONFIG;
      irq_mask_q      <= `RST_IRQ_MASK;
      for (k = 0; k < 2; k = k + 1) begin
        sflt_q[k] <= `RST_FILTER;
        ew0_q[k]  <= `RST_FILTER;
        ew1_q[k]  <= `RST_FILTER;
      end
      for (k = 0; k < 8; k = k + 1) begin
        tid_q[k] <= 29'h0;
      end
    end else begin
      if (wr_ok) begin
        if (paddr == `OFS_GLOBAL_FILTER_CONFIG) begin
          global_filter_config_q <= pwdata;
        end else if (paddr == `OFS_TX_CONFIG) begin
          tx_queue_mode_q <= pwdata[0];
        end else if (paddr == `OFS_IRQ_MASK) begin
          irq_mask_q <= pwdata[2:0];
        end else if (paddr == `OFS_STD_FILTER0) begin
          sflt_q[0] <= pwdata;
        end else if (paddr == `OFS_STD_FILTER1) begin
          sflt_q[1] <= pwdata;
        end else if (paddr == `OFS_EXT_FILTER0_W0) begin
          ew0_q[0] <= pwdata;
        end else if (paddr == `OFS_EXT_FILTER0_W1) begin
          ew1_q[0] <= pwdata;
        end else if (paddr == `OFS_EXT_FILTER1_W0) begin
          ew0_q[1] <= pwdata;
        end else if (paddr == `OFS_EXT_FILTER1_W1) begin
          ew1_q[1] <= pwdata;
        end else if ({paddr[7:4], 4'h0} == `OFS_TX_BUF_ID_BASE) begin
          tid_q[{1'b0, paddr[3:2]}] <= pwdata[28:0];
        end else if (push) begin
          tid_q[{1'b1, put_q}] <= pwdata[28:0];
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Interrupt flags
  // --------------------------------------------------------------------
  wire [2:0] irq_clr = (wr_ok && paddr == `OFS_IRQ_STATUS) ?
                       pwdata[2:0] : 3'h0;
  wire [2:0] irq_set = {tfe_ev, done_ev,
                        rx_frame_valid & rx_prio};
  wire [2:0] irq_d   = (irq_status_q & ~irq_clr) | irq_set;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= 3'h0;
      irq_q        <= 1'b0;
    end else begin
      irq_status_q <= irq_d;
      irq_q        <= |(irq_d & irq_mask_q);
    end
  end

endmodule
`default_nettype wire

// >>> can_filt_tx_regs.vh
// Register offsets, field positions and reset values of the CAN filter/Tx block
`ifndef CAN_FILT_TX_REGS_VH
`define CAN_FILT_TX_REGS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_GLOBAL_FILTER_CONFIG 8'h00
`define OFS_TX_CONFIG            8'h04
`define OFS_IRQ_STATUS           8'h08
`define OFS_IRQ_MASK             8'h0c
`define OFS_TX_ADD_REQUEST       8'h10
`define OFS_TX_OCCURRED_BITS     8'h14
`define OFS_TX_FIFO_PUSH         8'h18
`define OFS_TX_PIPE_STATUS       8'h1c
`define OFS_STD_FILTER0          8'h20
`define OFS_STD_FILTER1          8'h24
`define OFS_EXT_FILTER0_W0       8'h28
`define OFS_EXT_FILTER0_W1       8'h2c
`define OFS_EXT_FILTER1_W0       8'h30
`define OFS_EXT_FILTER1_W1       8'h34
`define OFS_TX_BUF_ID_BASE       8'h40

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define NM_EXT_LSB    2
`define NM_STD_LSB    4
`define SF_TYPE_LSB   30
`define SF_CFG_LSB    27
`define SF_IDA_LSB    16
`define SF_IDB_LSB    0
`define EF_CFG_LSB    29
`define EF_TYPE_LSB   30
`define IRQ_PRIO_BIT  0
`define IRQ_DONE_BIT  1
`define IRQ_EMPTY_BIT 2

// ----------------------------------------------------------------------
// Encodings and reset values
// ----------------------------------------------------------------------
`define FT_RANGE      2'h0
`define FT_DUAL       2'h1
`define FT_CLASSIC    2'h2
`define FC_OFF        3'h0
`define FC_FIFO0      3'h1
`define FC_FIFO1      3'h2
`define FC_REJECT     3'h3
`define FC_PRIO       3'h4
`define FC_PRIO_FIFO1 3'h6
`define FC_STORE_ALT  3'h7
`define GA_FIFO0      2'h0
`define GA_FIFO1      2'h1
`define RST_GLOBAL_FILTER_CONFIG 32'h00000000
`define RST_TX_CONFIG 1'h0
`define RST_FILTER    32'h00000000
`define RST_IRQ_MASK  3'h0

`endif

// >>> filter_match.v
// Single acceptance filter element compare: range, dual id or value/mask
`default_nettype none
`include "can_filt_tx_regs.vh"

module filter_match #(
  parameter W = 11
) (
  input  wire [W-1:0] id,
  input  wire [W-1:0] id_a,
  input  wire [W-1:0] id_b,
  input  wire [1:0]   ftype,
  output reg          hit
);

  always @* begin
    case (ftype)
      `FT_RANGE:   hit = (id >= id_a) && (id <= id_b);
      `FT_DUAL:    hit = (id == id_a) || (id == id_b);
      `FT_CLASSIC: hit = ((id ^ id_a) & id_b) == {W{1'b0}};
      default:     hit = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// >>> can_filt_tx_asserts.sv
// Port assertions for the CAN filter and transmit handler
`default_nettype none
module can_filt_tx_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rx_frame_valid,
  input wire logic        rx_store_valid,
  input wire logic        rx_store_fifo1,
  input wire logic        tx_req,
  input wire logic [28:0] tx_id,
  input wire logic [2:0]  tx_index,
  input wire logic        tx_done,
  input wire logic        tx_fail
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // --------------------
  // Properties
  // --------------------
  a_store_cause: assert property (
    rx_store_valid |-> $past(rx_frame_valid)) else $error("store w/o frame");
  a_fifo1_qual: assert property (
    rx_store_fifo1 |-> rx_store_valid) else $error("fifo1 w/o store");
  a_access_ans: assert property (
    psel && penable && !pready |=> pready) else $error("late pready");
  a_pready_pulse: assert property (
    pready |=> !pready) else $error("pready held");
  a_err_qual: assert property (
    pslverr |-> pready) else $error("pslverr w/o pready");
  a_rdata_idle: assert property (
    !pready |-> prdata == 32'h0) else $error("prdata not idle");
  a_req_hold: assert property (
    tx_req && !tx_done && !tx_fail |=> tx_req && $stable(tx_id)
      && $stable(tx_index)) else $error("request not held");
  a_req_drop: assert property (
    tx_req && (tx_done || tx_fail) |=> !tx_req) else $error("req stuck");
endmodule

bind can_rx_filter_tx_handler can_filt_tx_asserts can_filt_tx_asserts_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_frame_valid(rx_frame_valid), .rx_store_valid(rx_store_valid),
  .rx_store_fifo1(rx_store_fifo1), .tx_req(tx_req), .tx_id(tx_id),
  .tx_index(tx_index), .tx_done(tx_done), .tx_fail(tx_fail)
);
`default_nettype wire

// >>> can_peer.sv
// Protocol engine and bus model at the far side of the block
`default_nettype none
module can_peer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        tx_req,
  input  wire logic [28:0] tx_id,
  input  wire logic [2:0]  tx_index,
  output var  logic        tx_done,
  output var  logic        tx_fail,
  output var  logic        rx_frame_valid,
  output var  logic        rx_frame_ext,
  output var  logic [28:0] rx_frame_id
);
  timeunit 1ns;
  timeprecision 1ps;
  int          delay = 4;
  int          fail_n = 0;
  int          cnt;
  logic [31:0] log_q[$];
  initial begin
    rx_frame_valid = 1'b0;
    rx_frame_ext = 1'b0;
    rx_frame_id = 29'h0;
  end
  // --------------------
  // Engine: answer after delay, fail on command
  // --------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_done <= 1'b0;
      tx_fail <= 1'b0;
      cnt <= 0;
    end else begin
      tx_done <= 1'b0;
      tx_fail <= 1'b0;
      if (tx_req && !tx_done && !tx_fail) begin
        cnt <= cnt + 1;
        if (cnt >= delay) begin
          cnt <= 0;
          if (fail_n > 0) begin
            fail_n <= fail_n - 1;
            tx_fail <= 1'b1;
          end else begin
            tx_done <= 1'b1;
            log_q.push_back({tx_index, tx_id});
          end
        end
      end
    end
  end
  // One received frame, then stale id scrambled
  task automatic send(input logic x, input logic [28:0] id);
    @(posedge pclk);
    rx_frame_valid <= 1'b1;
    rx_frame_ext <= x;
    rx_frame_id <= id;
    @(posedge pclk);
    rx_frame_valid <= 1'b0;
    rx_frame_id <= ~id;
  endtask
endmodule
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the CAN filter and transmit handler
`default_nettype none
`include "can_filt_tx_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        rx_frame_valid, rx_frame_ext, rx_store_valid, rx_store_fifo1;
  logic        tx_req, tx_done, tx_fail, irq, e, st;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [28:0] rx_frame_id, tx_id;
  logic [2:0]  tx_index;
  logic [31:0] exp_q[4] = '{32'h5, 32'h20000005, 32'h80000300, 32'ha0000301};
  int          num_errors = 0;
  int          n_tests = 0;
  int          cyc = 0;

  can_rx_filter_tx_handler can_rx_filter_tx_handler_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_frame_valid(rx_frame_valid),
    .rx_frame_ext(rx_frame_ext), .rx_frame_id(rx_frame_id),
    .rx_store_valid(rx_store_valid), .rx_store_fifo1(rx_store_fifo1),
    .tx_req(tx_req), .tx_id(tx_id), .tx_index(tx_index),
    .tx_done(tx_done), .tx_fail(tx_fail), .irq(irq));
  can_peer can_peer_i (
    .pclk(pclk), .presetn(presetn), .tx_req(tx_req), .tx_id(tx_id),
    .tx_index(tx_index), .tx_done(tx_done), .tx_fail(tx_fail),
    .rx_frame_valid(rx_frame_valid), .rx_frame_ext(rx_frame_ext),
    .rx_frame_id(rx_frame_id));

  // --------------------
  // Clock, timeout, tasks
  // --------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 10000) begin
      num_errors++;
      results();
    end
  end
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    cmp(rd, x);
  endtask
  task automatic frm(input logic x, input logic [28:0] id, input logic [1:0] s);
    can_peer_i.send(x, id);
    @(posedge pclk);
    cmp({30'h0, rx_store_fifo1, rx_store_valid}, {30'h0, s});
  endtask
  task automatic filt(input logic k, input logic [2:0] c);
    if (k) begin
      wr(`OFS_EXT_FILTER0_W1, 32'h80000000);
      wr(`OFS_EXT_FILTER0_W0, {c, 29'h1555555});
    end else begin
      wr(`OFS_STD_FILTER0, {2'b10, c, 27'h5a50000});
    end
  endtask

  // --------------------
  // Main sequence
  // --------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`OFS_GLOBAL_FILTER_CONFIG, `RST_GLOBAL_FILTER_CONFIG);
    rdc(`OFS_TX_CONFIG, 32'h0);
    rdc(8'hfc, 32'h0);
    cmp({31'h0, e}, 32'h1);
    $display("test reset done");
    wr(`OFS_GLOBAL_FILTER_CONFIG, 32'h28);
    for (int k = 0; k < 2; k++) begin
      for (int c = 0; c < 8; c++) begin
        st = (c != 0 && c != 3 && c != 4);
        filt(k[0], c[2:0]);
        frm(k[0], 29'h0abcdef1, {st & (c == 2 || c == 6), st});
        rdc(`OFS_IRQ_STATUS, {31'h0, c >= 4 && c <= 6});
        wr(`OFS_IRQ_STATUS, 32'h1);
      end
      filt(k[0], 3'h0);
    end
    wr(`OFS_GLOBAL_FILTER_CONFIG, 32'h14);
    for (int k = 0; k < 2; k++) begin
      filt(k[0], 3'h5);
      frm(k[0], 29'h0abcdef1, 2'b01);
      wr(`OFS_IRQ_STATUS, 32'h1);
      frm(!k[0], 29'h0abcdef1, 2'b11);
      rdc(`OFS_IRQ_STATUS, 32'h0);
      filt(k[0], 3'h0);
    end
    wr(`OFS_GLOBAL_FILTER_CONFIG, 32'h28);
    wr(`OFS_STD_FILTER0, 32'h912307ff);
    wr(`OFS_STD_FILTER1, 32'h88000000);
    frm(1'b0, 29'h123, 2'b11);
    frm(1'b0, 29'h124, 2'b01);
    $display("test filters done");
    wr(`OFS_TX_BUF_ID_BASE, 32'h5);
    wr(`OFS_TX_BUF_ID_BASE + 8'h04, 32'h5);
    can_peer_i.delay = 30;
    can_peer_i.fail_n = 1;
    wr(`OFS_TX_FIFO_PUSH, 32'h300);
    wr(`OFS_TX_FIFO_PUSH, 32'h301);
    wr(`OFS_TX_ADD_REQUEST, 32'h3);
    while (can_peer_i.log_q.size() < 4) @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      cmp(can_peer_i.log_q[i], exp_q[i]);
    end
    rdc(`OFS_TX_OCCURRED_BITS, 32'h3);
    rdc(`OFS_IRQ_STATUS, 32'h6);
    $display("test transmit done");
    cmp({31'h0, irq}, 32'h0);
    wr(`OFS_IRQ_MASK, 32'h6);
    repeat (2) @(posedge pclk);
    cmp({31'h0, irq}, 32'h1);
    wr(`OFS_IRQ_STATUS, 32'h0);
    rdc(`OFS_IRQ_STATUS, 32'h6);
    wr(`OFS_IRQ_STATUS, 32'h6);
    rdc(`OFS_IRQ_STATUS, 32'h0);
    repeat (2) @(posedge pclk);
    cmp({31'h0, irq}, 32'h0);
    $display("test interrupt done");
    wr(`OFS_TX_CONFIG, 32'h1);
    wr(`OFS_TX_BUF_ID_BASE + 8'h08, 32'h1);
    wr(`OFS_TX_ADD_REQUEST, 32'h4);
    wr(`OFS_TX_FIFO_PUSH, 32'h302);
    wr(`OFS_TX_FIFO_PUSH, 32'h301);
    while (can_peer_i.log_q.size() < 7) @(posedge pclk);
    cmp(can_peer_i.log_q[4], 32'h40000001);
    cmp(can_peer_i.log_q[5], 32'he0000301);
    cmp(can_peer_i.log_q[6], 32'hc0000302);
    $display("test queue mode done");
    results();
  end
endmodule
`default_nettype wire
